// ===== shared/bsl_defs.svh
`ifndef BSL_DEFS_SVH
`define BSL_DEFS_SVH

// Local clock period and the word size of this end.
`define BSL_CLK_NS 40
`define BSL_WORD_W 16
`define BSL_IDX_W 4
`define BSL_TIMER_W 5
`define BSL_MSG_CNT_W 16

// Data and final-bit setup ahead of the bit-offered strobe, rounded up.
`define BSL_SETUP_NS 500
`define BSL_SETUP_CYC ((`BSL_SETUP_NS + `BSL_CLK_NS - 1) / `BSL_CLK_NS)

// Least strobe off times for short and long connections, rounded up.
`define BSL_OFF_SHORT_NS 50
`define BSL_OFF_LONG_NS 1000
`define BSL_OFF_SHORT_CYC ((`BSL_OFF_SHORT_NS + `BSL_CLK_NS - 1) / `BSL_CLK_NS)
`define BSL_OFF_LONG_CYC ((`BSL_OFF_LONG_NS + `BSL_CLK_NS - 1) / `BSL_CLK_NS)

// Quiet time after raising ready: 1/10 second.
`define BSL_QUIET_NS 100000000
`define BSL_QUIET_CYC (`BSL_QUIET_NS / `BSL_CLK_NS)

// Longest message that must be accepted, in bits; zero means unlimited.
`define BSL_MAX_BITS 8160

`endif

// ===== shared/bsl_pkg.sv
`include "bsl_defs.svh"

package bsl_pkg;

  typedef logic [`BSL_WORD_W-1:0] bsl_word_t;
  typedef logic [`BSL_IDX_W-1:0] bsl_idx_t;
  typedef logic [`BSL_TIMER_W-1:0] bsl_timer_t;

  typedef enum logic [2:0] {
    BSL_TX_IDLE,
    BSL_TX_WAIT_REQ,
    BSL_TX_SETUP,
    BSL_TX_OFFER,
    BSL_TX_OFF
  } bsl_tx_e;

  typedef enum logic {
    BSL_RX_HOLD,
    BSL_RX_WAIT
  } bsl_rx_e;

  // Off-time hold count, loaded as a count-down that ends at zero.
  function automatic bsl_timer_t bsl_off_hold(input logic long_link);
    bsl_off_hold = long_link ? bsl_timer_t'(`BSL_OFF_LONG_CYC - 1) :
                               bsl_timer_t'(`BSL_OFF_SHORT_CYC - 1);
  endfunction

  // Left-justify a partial word so the unused low positions are zeros.
  function automatic bsl_word_t bsl_pad(input bsl_word_t acc, input bsl_idx_t idx);
    bsl_pad = acc << (bsl_idx_t'(`BSL_WORD_W - 1) - idx);
  endfunction

endpackage

// ===== shared/bsl_if.sv
interface bsl_if;
  // Home to foreign data stream and the home request for foreign bits.
  logic hf_data;
  logic hf_final_bit;
  logic hf_bit_offered;
  logic hf_next_bit_request;
  logic home_ready;
  // Foreign to home data stream and the foreign request for home bits.
  logic fh_data;
  logic fh_final_bit;
  logic fh_bit_offered;
  logic fh_next_bit_request;
  logic foreign_ready;

  modport home (
    output hf_data, hf_final_bit, hf_bit_offered, hf_next_bit_request, home_ready,
    input fh_data, fh_final_bit, fh_bit_offered, fh_next_bit_request, foreign_ready
  );

  modport foreign (
    input hf_data, hf_final_bit, hf_bit_offered, hf_next_bit_request, home_ready,
    output fh_data, fh_final_bit, fh_bit_offered, fh_next_bit_request, foreign_ready
  );
endinterface

// ===== verilog/bsl_sync.sv
module bsl_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ===== verilog/bsl_home.sv
`include "bsl_defs.svh"

module bsl_home #(
  parameter int unsigned QUIET_CYCLES = `BSL_QUIET_CYC,
  parameter int unsigned MAX_BITS = `BSL_MAX_BITS,
  parameter bit DISCARD_LONG = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link to the foreign end
  bsl_if.home link,
  // Control and status
  input wire logic link_enable,
  input wire logic long_link,
  input wire logic error_clear,
  output logic link_up,
  output logic link_error,
  // Transmit words
  input wire bsl_pkg::bsl_word_t tx_word,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  // Received words
  output bsl_pkg::bsl_word_t rx_word,
  output logic rx_last,
  output logic rx_overlong,
  output logic rx_valid
);
  import bsl_pkg::*;

  logic [4:0] sync_q;
  logic ready_out;
  logic [31:0] quiet_cnt;
  logic quiet_done;
  logic ready_seen;
  bsl_tx_e tx_state;
  bsl_word_t tx_shift;
  bsl_idx_t tx_idx;
  bsl_timer_t tx_timer;
  logic tx_last_word;
  logic out_data;
  logic out_final;
  logic out_offered;
  bsl_rx_e rx_state;
  bsl_word_t rx_acc;
  bsl_idx_t rx_idx;
  bsl_timer_t rx_timer;
  logic [`BSL_MSG_CNT_W-1:0] rx_msg_bits;
  logic out_request;

  bsl_sync #(.WIDTH(5)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({link.fh_bit_offered, link.fh_next_bit_request, link.foreign_ready,
        link.fh_data, link.fh_final_bit}),
    .q(sync_q)
  );

  wire in_offered = sync_q[4];
  wire in_request = sync_q[3];
  wire in_ready = sync_q[2];
  wire in_data = sync_q[1];
  wire in_final = sync_q[0];

  // Both engines are held in reset until the quiet time has passed and the
  // foreign end reports ready, so a flapping relay cannot start a transfer.
  wire active = quiet_done && in_ready;
  wire ready_drop = ready_seen && !in_ready;

  assign link.home_ready = ready_out;
  assign link.hf_data = out_data;
  assign link.hf_final_bit = out_final;
  assign link.hf_bit_offered = out_offered;
  assign link.hf_next_bit_request = out_request;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ready_out <= 1'b0;
      quiet_cnt <= '0;
      quiet_done <= 1'b0;
    end else begin
      ready_out <= link_enable;
      if (!ready_out || !link_enable) begin
        quiet_cnt <= '0;
        quiet_done <= 1'b0;
      end else if (!quiet_done) begin
        if (quiet_cnt == QUIET_CYCLES - 1) begin
          quiet_done <= 1'b1;
        end
        quiet_cnt <= quiet_cnt + 32'h0000_0001;
      end
    end
  end

  // The set term wins over a clear arriving in the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ready_seen <= 1'b0;
      link_error <= 1'b0;
      link_up <= 1'b0;
    end else begin
      ready_seen <= in_ready;
      link_error <= ready_drop || (link_error && !error_clear);
      link_up <= active;
    end
  end

  // Sender.
  wire tx_take = tx_valid && tx_ready;
  wire tx_bit_last = tx_last_word && (tx_idx == '0);

  always_ff @(posedge clk) begin
    if (!rst_b || !active) begin
      tx_state <= BSL_TX_IDLE;
      tx_shift <= '0;
      tx_idx <= '0;
      tx_timer <= rst_b ? bsl_off_hold(long_link) : '0;
      tx_last_word <= 1'b0;
      tx_ready <= 1'b0;
      out_offered <= 1'b0;
      // A dropped link lowers the strobe but leaves data and final bit in place.
      if (!rst_b) begin
        out_data <= 1'b0;
        out_final <= 1'b0;
      end
    end else begin
      case (tx_state)
        BSL_TX_IDLE: begin
          tx_ready <= !tx_take;
          if (tx_take) begin
            tx_shift <= tx_word;
            tx_last_word <= tx_last;
            tx_idx <= bsl_idx_t'(`BSL_WORD_W - 1);
            tx_state <= BSL_TX_WAIT_REQ;
          end
        end
        BSL_TX_WAIT_REQ: begin
          if (tx_timer != '0) begin
            tx_timer <= tx_timer - 1'b1;
          end else if (in_request) begin
            out_data <= tx_shift[`BSL_WORD_W-1];
            out_final <= tx_bit_last;
            tx_timer <= bsl_timer_t'(`BSL_SETUP_CYC - 1);
            tx_state <= BSL_TX_SETUP;
          end
        end
        BSL_TX_SETUP: begin
          if (tx_timer == '0) begin
            out_offered <= 1'b1;
            tx_state <= BSL_TX_OFFER;
          end else begin
            tx_timer <= tx_timer - 1'b1;
          end
        end
        BSL_TX_OFFER: begin
          if (!in_request) begin
            out_offered <= 1'b0;
            tx_timer <= bsl_off_hold(long_link);
            tx_state <= BSL_TX_OFF;
          end
        end
        BSL_TX_OFF: begin
          if (tx_timer != '0) begin
            tx_timer <= tx_timer - 1'b1;
          end else if (tx_idx == '0) begin
            tx_ready <= 1'b1;
            tx_state <= BSL_TX_IDLE;
          end else begin
            tx_idx <= tx_idx - 1'b1;
            tx_shift <= {tx_shift[`BSL_WORD_W-2:0], 1'b0};
            tx_state <= BSL_TX_WAIT_REQ;
          end
        end
        default: begin
          tx_state <= BSL_TX_IDLE;
        end
      endcase
    end
  end

  // Receiver. Data and final bit are read only in the cycle the bit is taken.
  wire rx_take = (rx_state == BSL_RX_WAIT) && in_offered;
  wire bsl_word_t rx_acc_next = {rx_acc[`BSL_WORD_W-2:0], in_data};
  wire rx_word_full = rx_idx == bsl_idx_t'(`BSL_WORD_W - 1);
  wire rx_end_word = rx_take && (in_final || rx_word_full);
  wire msg_sat = rx_msg_bits == '1;
  wire [`BSL_MSG_CNT_W-1:0] msg_bits_next = msg_sat ? rx_msg_bits :
                                            rx_msg_bits + 1'b1;
  wire over_limit = (MAX_BITS != 0) && (32'(msg_bits_next) > MAX_BITS);
  // Keeping the final word lets software see the overlong flag even when
  // the body of the message was dropped.
  wire rx_emit = rx_end_word && !(DISCARD_LONG && over_limit && !in_final);

  always_ff @(posedge clk) begin
    if (!rst_b || !active) begin
      rx_state <= BSL_RX_HOLD;
      // Reloading the off timer while the link is down keeps the request low
      // for the full off time across a ready flap.
      rx_timer <= rst_b ? bsl_off_hold(long_link) : '0;
      out_request <= 1'b0;
    end else begin
      case (rx_state)
        BSL_RX_HOLD: begin
          if (rx_timer != '0) begin
            rx_timer <= rx_timer - 1'b1;
          end else if (!in_offered) begin
            out_request <= 1'b1;
            rx_state <= BSL_RX_WAIT;
          end
        end
        BSL_RX_WAIT: begin
          if (in_offered) begin
            out_request <= 1'b0;
            rx_timer <= bsl_off_hold(long_link);
            rx_state <= BSL_RX_HOLD;
          end
        end
        default: begin
          rx_state <= BSL_RX_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || !active) begin
      rx_acc <= '0;
      rx_idx <= '0;
      rx_msg_bits <= '0;
      rx_word <= '0;
      rx_last <= 1'b0;
      rx_overlong <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= rx_emit;
      if (rx_take) begin
        rx_acc <= rx_end_word ? '0 : rx_acc_next;
        rx_idx <= rx_end_word ? '0 : rx_idx + 1'b1;
        rx_msg_bits <= in_final ? '0 : msg_bits_next;
      end
      if (rx_emit) begin
        // Only zeros fill the tail; no marker bit is placed after the data.
        rx_word <= bsl_pad(rx_acc_next, rx_idx);
        rx_last <= in_final;
        rx_overlong <= in_final && over_limit;
      end
    end
  end
endmodule

// ===== verilog/bsl_foreign.sv
`include "bsl_defs.svh"

module bsl_foreign (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link to the home end
  bsl_if.foreign link,
  // Control
  input wire logic link_enable,
  // Transmit words
  input wire bsl_pkg::bsl_word_t tx_word,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  // Received words
  output bsl_pkg::bsl_word_t rx_word,
  output logic rx_last,
  output logic rx_valid
);
  import bsl_pkg::*;

  logic [4:0] sync_q;
  logic ready_out;
  bsl_tx_e tx_state;
  bsl_word_t tx_shift;
  bsl_idx_t tx_idx;
  bsl_timer_t tx_timer;
  logic tx_last_word;
  logic out_data;
  logic out_final;
  logic out_offered;
  logic out_request;
  bsl_word_t rx_acc;
  bsl_idx_t rx_idx;

  bsl_sync #(.WIDTH(5)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({link.hf_bit_offered, link.hf_next_bit_request, link.home_ready,
        link.hf_data, link.hf_final_bit}),
    .q(sync_q)
  );

  wire in_offered = sync_q[4];
  wire in_request = sync_q[3];
  wire active = sync_q[2] && ready_out;
  wire in_data = sync_q[1];
  wire in_final = sync_q[0];

  assign link.foreign_ready = ready_out;
  assign link.fh_data = out_data;
  assign link.fh_final_bit = out_final;
  assign link.fh_bit_offered = out_offered;
  assign link.fh_next_bit_request = out_request;

  wire tx_take = tx_valid && tx_ready;

  always_ff @(posedge clk) begin
    if (!rst_b || !active) begin
      tx_state <= BSL_TX_IDLE;
      tx_shift <= '0;
      tx_idx <= '0;
      tx_timer <= '0;
      tx_last_word <= 1'b0;
      tx_ready <= 1'b0;
      out_data <= 1'b0;
      out_final <= 1'b0;
      out_offered <= 1'b0;
    end else begin
      case (tx_state)
        BSL_TX_IDLE: begin
          tx_ready <= !tx_take;
          if (tx_take) begin
            tx_shift <= tx_word;
            tx_last_word <= tx_last;
            tx_idx <= bsl_idx_t'(`BSL_WORD_W - 1);
            tx_state <= BSL_TX_WAIT_REQ;
          end
        end
        BSL_TX_WAIT_REQ: begin
          if (in_request) begin
            out_data <= tx_shift[`BSL_WORD_W-1];
            out_final <= tx_last_word && (tx_idx == '0);
            tx_timer <= bsl_timer_t'(`BSL_SETUP_CYC - 1);
            tx_state <= BSL_TX_SETUP;
          end
        end
        BSL_TX_SETUP: begin
          if (tx_timer == '0) begin
            out_offered <= 1'b1;
            tx_state <= BSL_TX_OFFER;
          end else begin
            tx_timer <= tx_timer - 1'b1;
          end
        end
        BSL_TX_OFFER: begin
          if (!in_request) begin
            out_offered <= 1'b0;
            tx_state <= BSL_TX_OFF;
          end
        end
        BSL_TX_OFF: begin
          if (tx_idx == '0) begin
            tx_ready <= 1'b1;
            tx_state <= BSL_TX_IDLE;
          end else begin
            tx_idx <= tx_idx - 1'b1;
            tx_shift <= {tx_shift[`BSL_WORD_W-2:0], 1'b0};
            tx_state <= BSL_TX_WAIT_REQ;
          end
        end
        default: begin
          tx_state <= BSL_TX_IDLE;
        end
      endcase
    end
  end

  // The request rises only once the offered strobe is seen low again.
  wire rx_take = out_request && in_offered;
  wire bsl_word_t rx_acc_next = {rx_acc[`BSL_WORD_W-2:0], in_data};
  wire rx_end_word = rx_take && (in_final || rx_idx == bsl_idx_t'(`BSL_WORD_W - 1));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ready_out <= 1'b0;
    end else begin
      ready_out <= link_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || !active) begin
      out_request <= 1'b0;
      rx_acc <= '0;
      rx_idx <= '0;
      rx_word <= '0;
      rx_last <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= rx_end_word;
      if (rx_take) begin
        out_request <= 1'b0;
        rx_acc <= rx_end_word ? '0 : rx_acc_next;
        rx_idx <= rx_end_word ? '0 : rx_idx + 1'b1;
      end else if (!out_request && !in_offered) begin
        out_request <= 1'b1;
      end
      if (rx_end_word) begin
        rx_word <= bsl_pad(rx_acc_next, rx_idx);
        rx_last <= in_final;
      end
    end
  end
endmodule

// ===== tb/bsl_link_chk.sv
module bsl_link_chk #(
  parameter int unsigned QUIET_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Home to foreign
  input wire logic hf_data,
  input wire logic hf_final_bit,
  input wire logic hf_bit_offered,
  input wire logic hf_next_bit_request,
  input wire logic home_ready,
  // Foreign to home
  input wire logic fh_bit_offered,
  input wire logic fh_next_bit_request
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cycles since the home relay came up, cleared while it is down.
  logic [31:0] quiet_cnt;
  // Cycles since the home data or final-bit line last moved; it saturates so a
  // long run of equal bits never wraps back below the setup figure.
  logic [4:0] setup_cnt;
  logic [1:0] hf_prev;
  wire logic hf_moved = hf_prev != {hf_data, hf_final_bit};
  wire logic [31:0] next_quiet_cnt = home_ready ? quiet_cnt + 32'h0000_0001 : 32'h0000_0000;
  wire logic [4:0] next_setup_cnt = hf_moved ? 5'h01 : setup_cnt + {4'h0, setup_cnt != 5'h1F};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      quiet_cnt <= 32'h0000_0000;
      setup_cnt <= 5'h00;
      hf_prev <= 2'h0;
    end else begin
      quiet_cnt <= next_quiet_cnt;
      setup_cnt <= next_setup_cnt;
      hf_prev <= {hf_data, hf_final_bit};
    end
  end
  home_req_order_a: assert property ($rose(hf_next_bit_request) |-> !fh_bit_offered)
    else $error("home request rose while a foreign bit was offered");
  fgn_req_order_a: assert property ($rose(fh_next_bit_request) |-> !hf_bit_offered)
    else $error("foreign request rose while a home bit was offered");
  home_offer_wait_a: assert property ($rose(hf_bit_offered) |-> fh_next_bit_request)
    else $error("home offered a bit without a request");
  fgn_offer_wait_a: assert property ($rose(fh_bit_offered) |-> hf_next_bit_request)
    else $error("foreign offered a bit without a request");
  quiet_time_a: assert property ((quiet_cnt < QUIET_CYCLES) |->
    !hf_bit_offered && !hf_next_bit_request)
    else $error("home strobe active inside the quiet time");
  req_off_a: assert property ($fell(hf_next_bit_request) |-> !hf_next_bit_request[*2])
    else $error("home request off time too short");
  offer_off_a: assert property ($fell(hf_bit_offered) |-> !hf_bit_offered[*2])
    else $error("home offered off time too short");
  setup_time_a: assert property ($rose(hf_bit_offered) |-> setup_cnt >= 5'h0D)
    else $error("home data not settled before offered rose");
  offer_hold_a: assert property (hf_bit_offered |=>
    $stable(hf_data) && $stable(hf_final_bit))
    else $error("home data moved while offered was high");
  sync_delay_a: assert property ($rose(fh_bit_offered) |-> hf_next_bit_request[*3])
    else $error("home answered faster than its synchroniser allows");
endmodule

// ===== tb/bit_serial_handshake_link_bench.sv
`include "bsl_defs.svh"

module bit_serial_handshake_link_bench;
  import bsl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned QUIET = 20;
  localparam int unsigned MAXB = 32;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  // Index 0 is the home end, index 1 the foreign end.
  logic [1:0] en = 2'b00;
  logic long_link = 1'b0;
  logic err_clr = 1'b0;
  bsl_word_t txw [2] = '{16'h0000, 16'h0000};
  logic [1:0] txl = 2'b00;
  logic [1:0] txv = 2'b00;
  logic [1:0] txr;
  bsl_word_t rxw [2];
  logic [1:0] rxl;
  logic [1:0] rxv;
  logic rx_over;
  logic link_up;
  logic link_error;
  logic [17:0] got [2][$];
  logic [1:0] bits [$];
  logic offer_q = 1'b0;
  int err_count = 0;
  int num_checks = 0;
  // Shortest home strobe off runs, gathered while the long off time is selected.
  int req_low = 0;
  int off_low = 0;
  int req_min = 1000;
  int off_min = 1000;

  bsl_if lnk ();
  bsl_home #(.QUIET_CYCLES(QUIET), .MAX_BITS(MAXB), .DISCARD_LONG(1'b0)) u_bsl_home (
    .clk(clk), .rst_b(rst_b), .link(lnk), .link_enable(en[0]), .long_link(long_link),
    .error_clear(err_clr), .link_up(link_up), .link_error(link_error),
    .tx_word(txw[0]), .tx_last(txl[0]), .tx_valid(txv[0]), .tx_ready(txr[0]),
    .rx_word(rxw[0]), .rx_last(rxl[0]), .rx_overlong(rx_over), .rx_valid(rxv[0])
  );
  bsl_foreign u_bsl_foreign (
    .clk(clk), .rst_b(rst_b), .link(lnk), .link_enable(en[1]),
    .tx_word(txw[1]), .tx_last(txl[1]), .tx_valid(txv[1]), .tx_ready(txr[1]),
    .rx_word(rxw[1]), .rx_last(rxl[1]), .rx_valid(rxv[1])
  );
  bsl_link_chk #(.QUIET_CYCLES(QUIET)) u_chk (
    .clk(clk), .rst_b(rst_b), .hf_data(lnk.hf_data), .hf_final_bit(lnk.hf_final_bit),
    .hf_bit_offered(lnk.hf_bit_offered), .hf_next_bit_request(lnk.hf_next_bit_request),
    .home_ready(lnk.home_ready), .fh_bit_offered(lnk.fh_bit_offered),
    .fh_next_bit_request(lnk.fh_next_bit_request)
  );

  always #20 clk = ~clk;

  // Received words and the home bit stream as it appears on the wire.
  always @(posedge clk) begin
    if (rxv[0] === 1'b1) got[0].push_back({rx_over, rxl[0], rxw[0]});
    if (rxv[1] === 1'b1) got[1].push_back({1'b0, rxl[1], rxw[1]});
    if (lnk.hf_bit_offered === 1'b1 && !offer_q) bits.push_back({lnk.hf_data, lnk.hf_final_bit});
    offer_q <= lnk.hf_bit_offered;
    if (lnk.hf_next_bit_request !== 1'b0 && req_low != 0 && req_low < req_min) req_min = req_low;
    req_low = (lnk.hf_next_bit_request === 1'b0) ? req_low + 1 : 0;
    if (lnk.hf_bit_offered !== 1'b0 && off_low != 0 && off_low < off_min) off_min = off_low;
    off_low = (lnk.hf_bit_offered === 1'b0) ? off_low + 1 : 0;
  end

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic stall();
    err_count++;
    $display("unexpected at %0t ns: wait ran out", $time);
    conclude();
  endtask

  task automatic compare(input logic [17:0] act, input logic [17:0] exp);
    num_checks++;
    if (act !== exp) begin
      err_count++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, act, exp);
    end
  endtask

  // The word is held until tx_ready is seen high at a rising edge.
  task automatic send(input int s, input bsl_word_t w, input logic last);
    int n;
    n = 0;
    @(negedge clk);
    txw[s] = w;
    txl[s] = last;
    txv[s] = 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (txr[s] !== 1'b1 && n < 3000);
    if (n >= 3000) stall();
    @(negedge clk);
    txv[s] = 1'b0;
  endtask

  task automatic wait_got(input int s, input int cnt);
    int n;
    n = 0;
    while (got[s].size() < cnt && n < 6000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 6000) stall();
  endtask

  task automatic wait_flag(input logic err);
    int n;
    n = 0;
    while ((err ? link_error : link_up) !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) stall();
  endtask

  task automatic t_bring_up();
    int n;
    n = 0;
    @(negedge clk);
    en = 2'b11;
    while (link_up !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    compare({17'h0_0000, n >= QUIET}, 18'h0_0001);
    compare({16'h0000, link_up, txr[0]}, 18'h0_0003);
    $display("test bring_up done");
  endtask

  task automatic t_home_msg();
    bsl_word_t w [2] = '{16'hA5C3, 16'h8001};
    int i;
    got[1].delete();
    bits.delete();
    send(0, w[0], 1'b0);
    send(0, w[1], 1'b1);
    wait_got(1, 2);
    compare(got[1][0], {2'b00, w[0]});
    compare(got[1][1], {2'b01, w[1]});
    compare(18'(bits.size()), 18'h0_0020);
    for (i = 0; i < 32 && i < bits.size(); i++) begin
      compare({16'h0000, bits[i]}, {16'h0000, w[i / 16][15 - i % 16], i == 31});
    end
    $display("test home_msg done");
  endtask

  // A message of exactly the length limit, then one that runs past it.
  task automatic t_fgn_msg();
    bsl_word_t w [5] = '{16'h8000, 16'h0001, 16'hFFFF, 16'h1234, 16'h5A5A};
    logic [4:0] lst = 5'h12;
    logic [4:0] ovr = 5'h10;
    int i;
    @(negedge clk);
    long_link = 1'b1;
    req_min = 1000;
    off_min = 1000;
    got[0].delete();
    for (i = 0; i < 5; i++) begin
      send(1, w[i], lst[i]);
    end
    wait_got(0, 5);
    for (i = 0; i < 5; i++) begin
      compare(got[0][i], {ovr[i], lst[i], w[i]});
    end
    compare({17'h0_0000, req_min >= `BSL_OFF_LONG_CYC}, 18'h0_0001);
    $display("test fgn_msg done");
  endtask

  task automatic t_link_drop();
    @(negedge clk);
    en = 2'b01;
    // Clear is held while the drop is seen, so the set must win.
    err_clr = 1'b1;
    wait_flag(1'b1);
    compare({17'h0_0000, link_error}, 18'h0_0001);
    err_clr = 1'b0;
    en = 2'b11;
    wait_flag(1'b0);
    compare({16'h0000, link_error, link_up}, 18'h0_0003);
    err_clr = 1'b1;
    @(negedge clk);
    err_clr = 1'b0;
    @(negedge clk);
    compare({17'h0_0000, link_error}, 18'h0_0000);
    got[0].delete();
    got[1].delete();
    fork
      send(0, 16'h1357, 1'b1);
      send(1, 16'hC0DE, 1'b1);
    join
    wait_got(0, 1);
    wait_got(1, 1);
    compare(got[0][0], {2'b01, 16'hC0DE});
    compare(got[1][0], {2'b01, 16'h1357});
    compare({16'h0000, req_min >= `BSL_OFF_LONG_CYC, off_min >= `BSL_OFF_LONG_CYC}, 18'h0_0003);
    $display("test link_drop done");
  endtask

  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    t_bring_up();
    t_home_msg();
    t_fgn_msg();
    t_link_drop();
    conclude();
  end
endmodule
